// file: src/mem_map_pkg.sv
package mem_map_pkg;

  // ------------------------------------------------------------
  // program space
  // ------------------------------------------------------------
  localparam int PC_WIDTH        = 23;
  localparam int PADDR_WIDTH     = 24;
  localparam int PWORD_WIDTH     = 24;
  localparam logic [23:0] USER_TOP_ADDR     = 24'h7F_FFFF;
  localparam logic [23:0] RESET_ADDR        = 24'h00_0000;
  localparam logic [23:0] RESET_TARGET_ADDR = 24'h00_0002;
  localparam logic [23:0] IVT_START_ADDR    = 24'h00_0004;
  localparam logic [23:0] IVT_END_ADDR      = 24'h00_00FF;
  localparam logic [23:0] ALT_IVT_START     = 24'h00_0100;
  localparam logic [23:0] ALT_IVT_END       = 24'h00_01FF;
  localparam logic [23:0] VECTOR_END_ADDR   = 24'h00_0200;
  localparam logic [22:0] PC_STEP           = 23'h00_0002;

  // config word pair, lower address per memory size
  localparam logic [23:0] CFG_ADDR_5K5  = 24'h00_2BFC;
  localparam logic [23:0] CFG_ADDR_11K  = 24'h00_57FC;
  localparam logic [23:0] CFG_ADDR_16K  = 24'h00_83FC;
  localparam logic [23:0] CFG_ADDR_22K  = 24'h00_ABFC;
  localparam logic [23:0] CFG_PAIR_STEP = 24'h00_0002;

  // ------------------------------------------------------------
  // data space
  // ------------------------------------------------------------
  localparam int DADDR_WIDTH  = 16;
  localparam int DWORD_WIDTH  = 16;
  localparam int DATA_BYTES   = 8192;
  localparam int WINDOW_BIT   = 15;
  localparam int CTRL_VIEW_BIT = 2;

  // ------------------------------------------------------------
  // loader states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    LD_IDLE  = 4'b0001,
    LD_LOW   = 4'b0010,
    LD_HIGH  = 4'b0100,
    LD_DONE  = 4'b1000
  } load_state_e;

endpackage

// file: src/data_ram.sv
`timescale 1ns/1ps
module data_ram #(
  parameter int WORDS = 4096,
  parameter int AW    = 12
) (
  input  wire logic          i_clk,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [15:0]   o_rdata,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [1:0]    i_wbe,
  input  wire logic [15:0]   i_wdata
);
  logic [15:0] mem [WORDS];

  // two byte lanes share decode, separate write lines
  always_ff @(posedge i_clk) begin
    if (i_wbe[0]) begin
      mem[i_waddr][7:0] <= i_wdata[7:0];
    end
    if (i_wbe[1]) begin
      mem[i_waddr][15:8] <= i_wdata[15:8];
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // data_ram

// file: src/cfg_unpack.sv
`timescale 1ns/1ps
module cfg_unpack (
  input  wire logic [15:0] i_word_lo,
  input  wire logic [15:0] i_word_hi,
  output logic      [15:0] o_cfg_a,
  output logic      [15:0] o_cfg_b,
  output logic      [15:0] o_cfg_c
);
  // scatter compact bits; order deliberately not preserved
  always_comb begin
    o_cfg_a = {i_word_hi[7:0], i_word_lo[15:8]};
    o_cfg_b = {i_word_lo[3:0], i_word_hi[15:12], i_word_lo[7:4], i_word_hi[11:8]};
    o_cfg_c = {8'h00, i_word_lo[0], i_word_hi[1], i_word_lo[2], i_word_hi[3],
               i_word_hi[4], i_word_lo[5], i_word_hi[6], i_word_lo[7]};
  end
endmodule // cfg_unpack

// file: src/memory_space_address_map.sv
`timescale 1ns/1ps
module memory_space_address_map
  import mem_map_pkg::*;
#(
  parameter int unsigned MEM_KWORDS_X2 = 44  // 11, 22, 32 or 44 (half-K words)
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // fetch side
  input  wire logic        i_pc_load,
  input  wire logic [22:0] i_pc_target,
  input  wire logic        i_pc_step_fwd,
  input  wire logic        i_pc_step_back,
  input  wire logic        i_vec_req,
  input  wire logic        i_vec_alt,
  input  wire logic [6:0]  i_vec_num,
  // table operation / view request into program space
  input  wire logic        i_table_read_op,
  input  wire logic [7:0]  i_table_page_register,
  input  wire logic [15:0] i_table_offset,
  input  wire logic [15:0] i_cpu_control_register,
  // program memory port (outside array)
  input  wire logic [23:0] i_prog_rdata,
  // data read generator
  input  wire logic        i_rd_en,
  input  wire logic        i_rd_byte,
  input  wire logic [15:0] i_rd_ea,
  // data write generator
  input  wire logic        i_wr_en,
  input  wire logic        i_wr_byte,
  input  wire logic [15:0] i_wr_ea,
  input  wire logic [15:0] i_wr_data,
  // outputs
  output logic      [23:0] o_prog_addr,
  output logic      [22:0] o_pc,
  output logic      [23:0] o_prog_data,
  output logic             o_prog_fault,
  output logic      [15:0] o_rd_data,
  output logic             o_rd_valid,
  output logic             o_view_req,
  output logic      [23:0] o_view_addr,
  output logic             o_addr_trap,
  output logic             o_cfg_ready,
  output logic      [15:0] o_cfg_a,
  output logic      [15:0] o_cfg_b,
  output logic      [15:0] o_cfg_c
);

  // refuse sizes for which no config pair address is known
  if (MEM_KWORDS_X2 != 11 && MEM_KWORDS_X2 != 22 && MEM_KWORDS_X2 != 32 && MEM_KWORDS_X2 != 44) begin : g_bad_size
    $error("unsupported program memory size");
  end
  // both vector tables must end below the reserved boundary
  if (ALT_IVT_END >= VECTOR_END_ADDR) begin : g_bad_vectors
    $error("vector tables overrun the reserved area");
  end

  // ------------------------------------------------------------
  // size dependent constants
  // ------------------------------------------------------------
  localparam logic [23:0] CFG_LO_ADDR = (MEM_KWORDS_X2 == 11) ? CFG_ADDR_5K5 :
                                        (MEM_KWORDS_X2 == 22) ? CFG_ADDR_11K :
                                        (MEM_KWORDS_X2 == 32) ? CFG_ADDR_16K : CFG_ADDR_22K;
  // hi word of the pair is the next program location, two addresses up
  localparam logic [23:0] CFG_HI_ADDR = CFG_LO_ADDR + CFG_PAIR_STEP;
  localparam int DWORDS = DATA_BYTES / 2;
  localparam int DAW    = $clog2(DWORDS);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    load_state_e state;
    logic [22:0] pc;
    logic [23:0] prog_addr;
    logic        prog_zero;
    logic        prog_fault;
    logic [23:0] prog_data;
    logic [15:0] cfg_lo;
    logic [15:0] cfg_hi;
    logic        cfg_ready;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] cfg_c;
    logic        rd_pend;
    logic        rd_byte;
    logic        rd_odd;
    logic        rd_zero;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        view_req;
    logic [23:0] view_addr;
    logic        trap;
  } map_s;

  map_s map_reg;
  map_s map_next;

  // ram port nets; the read port runs every cycle, the pend flag decides use
  logic [15:0] ram_rdata;
  logic [DAW-1:0] ram_raddr;
  logic [DAW-1:0] ram_waddr;
  logic [1:0]  ram_wbe;
  logic [15:0] ram_wdata;
  logic [15:0] unp_a;
  logic [15:0] unp_b;
  logic [15:0] unp_c;

  // ------------------------------------------------------------
  // leaf instances
  // ------------------------------------------------------------
  // ram read data is registered, the first of the two cycles of read latency
  data_ram #(
    .WORDS (DWORDS),
    .AW    (DAW)
  ) u_ram (
    .i_clk   (i_clk),
    .i_raddr (ram_raddr),
    .o_rdata (ram_rdata),
    .i_waddr (ram_waddr),
    .i_wbe   (ram_wbe),
    .i_wdata (ram_wdata)
  );

  cfg_unpack u_unpack (
    .i_word_lo (map_reg.cfg_lo),
    .i_word_hi (map_reg.cfg_hi),
    .o_cfg_a   (unp_a),
    .o_cfg_b   (unp_b),
    .o_cfg_c   (unp_c)
  );

  // ------------------------------------------------------------
  // data write path: separate generator, lane enables
  // ------------------------------------------------------------
  logic wr_in_ram;
  logic wr_misalign;
  always_comb begin
    wr_in_ram   = (i_wr_ea[WINDOW_BIT] == 1'b0) && (int'(i_wr_ea) < DATA_BYTES);
    wr_misalign = i_wr_en && !i_wr_byte && i_wr_ea[0];
    ram_waddr   = i_wr_ea[DAW:1];
    ram_wdata   = i_wr_byte ? {i_wr_data[7:0], i_wr_data[7:0]} : i_wr_data;
    ram_wbe     = 2'b00;
    // writes before the config copy ends are dropped: the core is not running yet
    if (i_wr_en && wr_in_ram && !wr_misalign && map_reg.cfg_ready) begin
      if (i_wr_byte) begin
        ram_wbe = i_wr_ea[0] ? 2'b10 : 2'b01;
      end else begin
        ram_wbe = 2'b11;
      end
    end
  end

  // read generator addresses the ram directly; word holds both lanes
  assign ram_raddr = i_rd_ea[DAW:1];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [23:0] req_addr;
  logic        view_on;
  logic        rd_misalign;
  always_comb begin
    map_next          = map_reg;
    map_next.rd_valid = 1'b0;
    map_next.view_req = 1'b0;
    map_next.trap     = 1'b0;
    // counter covers only the user half, so plain fetches can never fault
    req_addr          = {1'b0, map_reg.pc};
    view_on           = i_cpu_control_register[CTRL_VIEW_BIT];
    rd_misalign       = i_rd_en && !i_rd_byte && i_rd_ea[0];

    unique case (map_reg.state)
      // copy config pair in, then let the core run from reset address
      LD_IDLE: begin
        map_next.prog_addr = CFG_LO_ADDR;
        map_next.state     = LD_LOW;
      end
      LD_LOW: begin
        map_next.cfg_lo    = i_prog_rdata[15:0];
        map_next.prog_addr = CFG_HI_ADDR;
        map_next.state     = LD_HIGH;
      end
      LD_HIGH: begin
        map_next.cfg_hi    = i_prog_rdata[15:0];
        map_next.state     = LD_DONE;
        map_next.prog_addr = RESET_ADDR;
        map_next.pc        = RESET_ADDR[22:0];
      end
      LD_DONE: begin
        map_next.cfg_ready = 1'b1;
        map_next.cfg_a     = unp_a;
        map_next.cfg_b     = unp_b;
        map_next.cfg_c     = unp_c;
        // program counter update
        // vector slots are two apart; both tables stay below the reserved boundary
        if (i_vec_req) begin
          map_next.pc = i_vec_alt ? (ALT_IVT_START[22:0] + {15'h0, i_vec_num, 1'b0}) :
                                    (IVT_START_ADDR[22:0] + {15'h0, i_vec_num, 1'b0});
        end else if (i_pc_load) begin
          map_next.pc = {i_pc_target[22:1], 1'b0};
        end else if (i_pc_step_fwd) begin
          map_next.pc = map_reg.pc + PC_STEP;
        end else if (i_pc_step_back) begin
          map_next.pc = map_reg.pc - PC_STEP;
        end
        // table op or view mapping takes the program port this cycle
        if (i_table_read_op) begin
          req_addr = {i_table_page_register, i_table_offset};
        end else if (i_rd_en && i_rd_ea[WINDOW_BIT] && view_on) begin
          req_addr = {i_table_page_register, 1'b1, i_rd_ea[14:0]};
        end else begin
          req_addr = {1'b0, map_next.pc};
        end
        map_next.prog_addr = req_addr;
        // upper half only by table read with page bit 7
        map_next.prog_fault = (req_addr > USER_TOP_ADDR) && !i_table_read_op;
        // gap between the config pair and the user top reads as zero
        map_next.prog_zero  = (req_addr <= USER_TOP_ADDR) &&
                              (req_addr > CFG_HI_ADDR + 24'h00_0001);
        map_next.prog_data  = map_reg.prog_zero || map_reg.prog_fault ? 24'h00_0000 :
                              {8'h00, i_prog_rdata[15:0]} | {i_prog_rdata[23:16], 16'h0000};
        // data read: two cycles of latency, the ram register then the output flop
        // a window read with the view bit set goes out to program space instead of the ram
        map_next.rd_pend = i_rd_en && !(i_rd_ea[WINDOW_BIT] && view_on);
        map_next.rd_byte = i_rd_byte;
        map_next.rd_odd  = i_rd_ea[0];
        map_next.rd_zero = i_rd_ea[WINDOW_BIT] || (int'(i_rd_ea) >= DATA_BYTES);
        if (i_rd_en && i_rd_ea[WINDOW_BIT] && view_on) begin
          map_next.view_req  = 1'b1;
          map_next.view_addr = req_addr;
        end
        // odd word access: the read still completes, the write lanes stay shut
        map_next.trap = rd_misalign || wr_misalign;
        if (map_reg.rd_pend) begin
          map_next.rd_valid = 1'b1;
          if (map_reg.rd_zero) begin
            map_next.rd_data = 16'h0000;
          end else if (map_reg.rd_byte) begin
            map_next.rd_data = {8'h00, map_reg.rd_odd ? ram_rdata[15:8] : ram_rdata[7:0]};
          end else begin
            map_next.rd_data = ram_rdata;
          end
        end
      end
      default: begin
        map_next.state = LD_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register; reset re-runs the config copy every time
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      map_reg       <= '0;
      map_reg.state <= LD_IDLE;
    end else begin
      map_reg <= map_next;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from flops
  // ------------------------------------------------------------
  // every output is a struct field, no logic after the flops
  assign o_prog_addr  = map_reg.prog_addr;
  assign o_pc         = map_reg.pc;
  assign o_prog_data  = map_reg.prog_data;
  assign o_prog_fault = map_reg.prog_fault;
  assign o_rd_data    = map_reg.rd_data;
  assign o_rd_valid   = map_reg.rd_valid;
  assign o_view_req   = map_reg.view_req;
  assign o_view_addr  = map_reg.view_addr;
  assign o_addr_trap  = map_reg.trap;
  assign o_cfg_ready  = map_reg.cfg_ready;
  assign o_cfg_a      = map_reg.cfg_a;
  assign o_cfg_b      = map_reg.cfg_b;
  assign o_cfg_c      = map_reg.cfg_c;

endmodule // memory_space_address_map

// file: sim/prog_mem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// program array stand-in
// ------------------------------------------------------------
module prog_mem_model (
  input  wire logic [23:0] i_addr,
  output logic      [23:0] o_data
);
  // top byte is always zero; the low word is scrambled so that
  // a stale or shifted address gives a different value
  assign o_data = {8'h00, i_addr[15:0] ^ 16'h5A5A};
endmodule  // prog_mem_model

// file: sim/memory_space_address_map_assertions.sv
`timescale 1ns/1ps
module memory_space_address_map_assertions
  import mem_map_pkg::*;
#(
  parameter int unsigned MEM_KWORDS_X2 = 44
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_pc_load,
  input wire logic        i_pc_step_fwd,
  input wire logic        i_vec_req,
  input wire logic        i_vec_alt,
  input wire logic [6:0]  i_vec_num,
  input wire logic [15:0] i_cpu_control_register,
  input wire logic        i_rd_en,
  input wire logic        i_rd_byte,
  input wire logic [15:0] i_rd_ea,
  input wire logic        i_wr_en,
  input wire logic        i_wr_byte,
  input wire logic [15:0] i_wr_ea,
  input wire logic [23:0] o_prog_addr,
  input wire logic [22:0] o_pc,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_view_req,
  input wire logic        o_addr_trap,
  input wire logic        o_cfg_ready
);
  localparam logic [23:0] CFG_LO = (MEM_KWORDS_X2 == 11) ? CFG_ADDR_5K5 : (MEM_KWORDS_X2 == 22) ? CFG_ADDR_11K :
                                   (MEM_KWORDS_X2 == 32) ? CFG_ADDR_16K : CFG_ADDR_22K;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ------------------------------------------------------------
  // reset fetch of the config pair, then vector start
  // ------------------------------------------------------------
  sequence s_cfg_fetch;
    o_prog_addr == CFG_LO ##1 o_prog_addr == CFG_LO + CFG_PAIR_STEP ##1 o_prog_addr == RESET_ADDR;
  endsequence
  a_cfg_fetch_order: assert property ($rose(i_rst_n) |-> ##1 s_cfg_fetch ##1 o_cfg_ready)
    else $error("config pair not fetched in order after reset");
  a_start_at_zero: assert property ($rose(o_cfg_ready) |-> o_pc == 23'h00_0000)
    else $error("execution does not start at zero");
  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  a_pc_step_two: assert property (o_cfg_ready && i_pc_step_fwd && !i_vec_req && !i_pc_load
                                  |=> o_pc == $past(o_pc) + PC_STEP)
    else $error("forward step is not two");
  a_pc_stays_even: assert property (o_pc[0] == 1'b0)
    else $error("program counter left lower word alignment");
  a_vector_slot: assert property (o_cfg_ready && i_vec_req
    |=> o_pc == ($past(i_vec_alt) ? 23'h00_0100 : 23'h00_0004) + {15'h0000, $past(i_vec_num), 1'b0})
    else $error("vector address wrong");
  a_vector_region: assert property (o_cfg_ready && i_vec_req |=> o_pc < 23'h00_0200)
    else $error("vector outside reserved region");
  // ------------------------------------------------------------
  // data space
  // ------------------------------------------------------------
  a_outside_zero: assert property (o_cfg_ready && i_rd_en && !i_rd_ea[15] && i_rd_ea >= 16'h2000
                                   |-> ##2 o_rd_data == 16'h0000)
    else $error("unimplemented data read not zero");
  a_byte_low_lane: assert property (o_cfg_ready && i_rd_en && i_rd_byte && !i_rd_ea[15]
                                    |-> ##2 o_rd_data[15:8] == 8'h00)
    else $error("byte read upper lane not clear");
  a_view_enabled: assert property (o_cfg_ready && i_rd_en && i_rd_ea[15] && i_cpu_control_register[CTRL_VIEW_BIT]
                                   |=> o_view_req)
    else $error("view window request missing");
  a_view_disabled: assert property (!i_cpu_control_register[CTRL_VIEW_BIT] [*2] |-> !o_view_req)
    else $error("view request while window off");
  a_odd_write_trap: assert property (o_cfg_ready && i_wr_en && !i_wr_byte && i_wr_ea[0] |-> ##[1:2] o_addr_trap)
    else $error("odd word write without trap");
  a_odd_read_trap: assert property (o_cfg_ready && i_rd_en && !i_rd_byte && i_rd_ea[0] |=> o_addr_trap)
    else $error("odd word read without trap");
endmodule  // memory_space_address_map_assertions

bind memory_space_address_map memory_space_address_map_assertions #(.MEM_KWORDS_X2(MEM_KWORDS_X2)) u_chk (
  .i_clk, .i_rst_n, .i_pc_load, .i_pc_step_fwd, .i_vec_req, .i_vec_alt, .i_vec_num, .i_cpu_control_register,
  .i_rd_en, .i_rd_byte, .i_rd_ea, .i_wr_en, .i_wr_byte, .i_wr_ea, .o_prog_addr, .o_pc, .o_rd_data,
  .o_view_req, .o_addr_trap, .o_cfg_ready
);

// file: sim/memory_space_address_map_bench.sv
`timescale 1ns/1ps
module memory_space_address_map_bench;
  import mem_map_pkg::*;
  logic        i_clk, i_rst_n, i_pc_load, i_pc_step_fwd, i_pc_step_back, i_vec_req, i_vec_alt, i_table_read_op;
  logic        i_rd_en, i_rd_byte, i_wr_en, i_wr_byte, o_prog_fault, o_rd_valid, o_view_req, o_addr_trap, o_cfg_ready;
  logic [6:0]  i_vec_num;
  logic [7:0]  i_table_page_register;
  logic [15:0] i_table_offset, i_cpu_control_register, i_rd_ea, i_wr_ea, i_wr_data, o_rd_data, o_cfg_a, o_cfg_b, o_cfg_c;
  logic [22:0] i_pc_target, o_pc;
  logic [23:0] i_prog_rdata, o_prog_addr, o_prog_data, o_view_addr;
  logic [15:0] rd;
  int          err_count = 0;
  int          checks_done = 0;

  memory_space_address_map u_dut (.i_clk, .i_rst_n, .i_pc_load, .i_pc_target, .i_pc_step_fwd, .i_pc_step_back,
    .i_vec_req, .i_vec_alt, .i_vec_num, .i_table_read_op, .i_table_page_register, .i_table_offset,
    .i_cpu_control_register, .i_prog_rdata, .i_rd_en, .i_rd_byte, .i_rd_ea, .i_wr_en, .i_wr_byte, .i_wr_ea,
    .i_wr_data, .o_prog_addr, .o_pc, .o_prog_data, .o_prog_fault, .o_rd_data, .o_rd_valid, .o_view_req,
    .o_view_addr, .o_addr_trap, .o_cfg_ready, .o_cfg_a, .o_cfg_b, .o_cfg_c);
  prog_mem_model u_prog (.i_addr(o_prog_addr), .o_data(i_prog_rdata));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  // inputs move 5 ns after the edge so the design never races them
  task automatic tick();
    @(posedge i_clk);
    #5;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_for(ref logic flag);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 8) begin
      tick();
      n++;
    end
    if (flag !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  // leading edge keeps back-to-back calls from toggling a strobe in one step
  task automatic data_write(input logic byte_op, input logic [15:0] ea, input logic [15:0] data);
    tick();
    i_wr_en = 1'b1;
    i_wr_byte = byte_op;
    i_wr_ea = ea;
    i_wr_data = data;
    tick();
    i_wr_en = 1'b0;
  endtask
  task automatic data_read(input logic byte_op, input logic [15:0] ea, output logic [15:0] data);
    i_rd_en = 1'b1;
    i_rd_byte = byte_op;
    i_rd_ea = ea;
    tick();
    i_rd_en = 1'b0;
    wait_for(o_rd_valid);
    data = o_rd_data;
  endtask
  // one-cycle strobe on a fetch-side or table read control
  task automatic strobe(ref logic sig);
    tick();
    sig = 1'b1;
    tick();
    sig = 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic scen_lanes();
    data_write(1'b0, 16'h0100, 16'h1234);
    data_read(1'b1, 16'h0101, rd);
    check(rd, 16'h0012);
    data_read(1'b1, 16'h0100, rd);
    check(rd, 16'h0034);
    data_write(1'b1, 16'h0101, 16'h00AB);
    data_read(1'b0, 16'h0100, rd);
    check(rd, 16'hAB34);
  endtask
  task automatic scen_outside();
    data_write(1'b0, 16'h1FFE, 16'hBEEF);
    data_write(1'b0, 16'h0000, 16'h0000);
    data_write(1'b0, 16'h2000, 16'hFFFF);
    data_read(1'b0, 16'h0000, rd);
    check(rd, 16'h0000);
    data_read(1'b0, 16'h1FFE, rd);
    check(rd, 16'hBEEF);
    data_read(1'b0, 16'h2000, rd);
    check(rd, 16'h0000);
    data_read(1'b0, 16'h8000, rd);
    check(rd, 16'h0000);
  endtask
  task automatic scen_trap();
    logic seen;
    data_write(1'b0, 16'h0202, 16'h1111);
    data_write(1'b0, 16'h0203, 16'h2222);
    seen = o_addr_trap;
    tick();
    check(seen | o_addr_trap, 1'b1);
    data_read(1'b0, 16'h0202, rd);
    check(rd, 16'h1111);
    data_read(1'b0, 16'h0203, rd);
    check(rd, 16'h1111);
  endtask
  task automatic scen_view();
    logic seen;
    i_cpu_control_register = 16'h0004;
    i_rd_en = 1'b1;
    i_rd_ea = 16'h8006;
    tick();
    i_rd_en = 1'b0;
    seen = o_view_req;
    check(o_view_addr, 24'h00_8006);
    check(o_prog_fault, 1'b0);
    tick();
    check(seen | o_view_req, 1'b1);
    // window with the page top bit set lands above the user half
    i_table_page_register = 8'h80;
    i_rd_en = 1'b1;
    tick();
    i_rd_en = 1'b0;
    check(o_view_addr, 24'h80_8006);
    check(o_prog_fault, 1'b1);
    i_table_page_register = 8'h00;
    i_cpu_control_register = 16'h0000;
  endtask
  task automatic scen_pc();
    i_pc_target = 23'h00_1235;
    strobe(i_pc_load);
    check(o_pc, 23'h00_1234);
    check(o_prog_addr, 24'h00_1234);
    strobe(i_pc_step_fwd);
    check(o_pc, 23'h00_1236);
    strobe(i_pc_step_back);
    strobe(i_pc_step_back);
    check(o_pc, 23'h00_1232);
    for (int k = 0; k < 4; k++) begin
      i_vec_alt = k[1];
      i_vec_num = k[0] ? 7'd125 : 7'd0;
      strobe(i_vec_req);
      check(o_pc, (k[1] ? 23'h00_0100 : 23'h00_0004) + (k[0] ? 23'd250 : 23'd0));
    end
  endtask
  task automatic scen_prog();
    i_table_page_register = 8'h80;
    i_table_offset = 16'h0010;
    strobe(i_table_read_op);
    check(o_prog_addr, 24'h80_0010);
    check(o_prog_fault, 1'b0);
    i_table_page_register = 8'h00;
    i_table_offset = 16'h0300;
    strobe(i_table_read_op);
    tick();
    check(o_prog_data, 24'h00_595A);
    i_table_offset = 16'hB000;
    strobe(i_table_read_op);
    tick();
    check(o_prog_data, 24'h00_0000);
  endtask
  // config pair of the default size, through the array stand-in and the unpacker
  task automatic cfg_words_check();
    check(o_cfg_a, 16'hA4F1);
    check(o_cfg_b, 16'h6FA1);
    check(o_cfg_c, 16'h0025);
  endtask
  // second reset in mid-run must fetch the config pair again
  task automatic scen_reset();
    i_rst_n = 1'b0;
    tick();
    check(o_cfg_ready, 1'b0);
    tick();
    i_rst_n = 1'b1;
    wait_for(o_cfg_ready);
    check(o_pc, 23'h00_0000);
    cfg_words_check();
  endtask

  // ------------------------------------------------------------
  // clock, reset and main sequence
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_n, i_pc_load, i_pc_step_fwd, i_pc_step_back, i_vec_req, i_vec_alt, i_table_read_op} = '0;
    {i_rd_en, i_rd_byte, i_wr_en, i_wr_byte, i_vec_num, i_table_page_register} = '0;
    {i_table_offset, i_cpu_control_register, i_rd_ea, i_wr_ea, i_wr_data, i_pc_target} = '0;
    repeat (3) tick();
    i_rst_n = 1'b1;
    wait_for(o_cfg_ready);
    check(o_pc, 23'h00_0000);
    cfg_words_check();
    scen_lanes();
    scen_outside();
    scen_trap();
    scen_view();
    scen_pc();
    scen_prog();
    scen_reset();
    close_out();
  end
endmodule  // memory_space_address_map_bench
